// ===== rtl/i2cee_consts.vh
// Summary of operation
// R1: Ack matching select byte in ninth clock
// R2: Ack both address bytes and each write byte
// R3: Read: shift eight bits, release ninth, continue
// R4: Master ends read by nack then STOP
// R5: Byte write: four bytes acked, then STOP
// R6: No select ack while programming is busy
// R7: Address is 9-bit page, 7-bit offset
// R8: Offset wraps within page, 128 bytes max
// R9: STOP after write data starts programming
// R10: Sample protect pin at fall before data
// R11: Protect high: nack data, reject whole write
// R12: Array starts with every byte erased FFh
// R13: Counter holds next location, wraps to zero
// R14: Read select: ack then send counter byte
// R15: Dummy write loads counter, then repeated START
// R16: Sequential read while acked, wraps array end
// R17: Select byte: type, three pins, direction
// R18: START and STOP are data edges, clock high
// R19: Sample on clock rise, change after fall
// R20: Mismatched select: silent until next START
// R21: STOP before data starts no programming
//
// Purpose: constants of the two-wire memory slave
// Assumes: included by bare name from the design file
// Notes: definitions only
`ifndef I2CEE_CONSTS_VH
`define I2CEE_CONSTS_VH
// ================================================
// Select byte layout and type code
`define I2CEE_TYPE_MSB 7
`define I2CEE_TYPE_LSB 4
`define I2CEE_PINS_MSB 3
`define I2CEE_PINS_LSB 1
`define I2CEE_DIR_BIT 0
`define I2CEE_TYPE_CODE 4'h5
// ================================================
// Array geometry and reset values
`define I2CEE_ADDR_W 16
`define I2CEE_OFS_W 7
`define I2CEE_PAGE_BYTES 128
`define I2CEE_ERASED 8'hff
`define I2CEE_BYTE_BITS 4'h8
// ================================================
// Timing: write cycle time and clock period
`define I2CEE_T_WR_MS 5
`define I2CEE_CLK_NS 8
`define I2CEE_WR_CYCLES ((`I2CEE_T_WR_MS * 1000000) / `I2CEE_CLK_NS)
`endif

// ===== rtl/i2cee_slave.v
// Purpose: two-wire serial slave front end of a 64K x 8 memory
// Assumes: all pins asynchronous to core_clk, core_clk far above SCL
// Notes: open-drain data pin, busy while programming
`timescale 1ns/100ps
`include "i2cee_consts.vh"

// ================================================
// Write-entry FIFO between serial side and page buffer
module i2cee_fifo
#(
    parameter W = 15,
    parameter D = 8,
    parameter AW = 3
)
(
    // Clock and control
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW:0] wp_ff;
    reg [AW:0] rp_ff;
    wire do_wr;
    wire do_rd;

    // Extra pointer bit tells full from empty
    assign out_valid = (wp_ff != rp_ff);
    assign in_ready = (wp_ff[AW-1:0] != rp_ff[AW-1:0]) || (wp_ff[AW] == rp_ff[AW]);
    assign out_data = mem[rp_ff[AW-1:0]];
    assign do_wr = in_valid && in_ready && clk_en;
    assign do_rd = out_valid && out_ready && clk_en;

    // Pointers
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            wp_ff <= {(AW+1){1'b0}};
            rp_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wp_ff <= wp_ff + 1'b1;
            if (do_rd)
                rp_ff <= rp_ff + 1'b1;
        end
    end

    // Storage
    always @(posedge core_clk)
    begin
        if (do_wr)
            mem[wp_ff[AW-1:0]] <= in_data;
    end
endmodule

// ================================================
// Slave top
module i2cee_slave
#(
    parameter WR_CYCLES = `I2CEE_WR_CYCLES,
    parameter FIFO_D = 8
)
(
    // Clock, reset, enable
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    // Serial bus
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    // Straps and protection
    input wire device_select_bit0,
    input wire device_select_bit1,
    input wire device_select_bit2,
    input wire write_protect,
    // Status
    output wire write_busy
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DSEL = 3'h1;
    localparam ST_AH = 3'h2;
    localparam ST_AL = 3'h3;
    localparam ST_WD = 3'h4;
    localparam ST_RD = 3'h5;
    localparam NPIN = 6;

    // ================================================
    // Pin synchronisers: three stages, accept when last two agree
    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] s1_ff;
    reg [NPIN-1:0] s2_ff;
    reg [NPIN-1:0] s3_ff;
    reg [NPIN-1:0] flt_ff;
    assign pin_raw = {write_protect, device_select_bit2, device_select_bit1, device_select_bit0, sda_in, scl_in};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1)
        begin : g_sync
            always @(posedge core_clk)
            begin
                if (rst)
                begin
                    s1_ff[gi] <= 1'b1;
                    s2_ff[gi] <= 1'b1;
                    s3_ff[gi] <= 1'b1;
                    flt_ff[gi] <= 1'b1;
                end
                else if (clk_en)
                begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi])
                        flt_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate

    wire scl_f = flt_ff[0];
    wire sda_f = flt_ff[1];
    wire [2:0] pins_f = flt_ff[4:2];
    wire wp_f = flt_ff[5];
    reg scl_d_ff;
    reg sda_d_ff;
    wire scl_rise = scl_f && !scl_d_ff;
    wire scl_fall = !scl_f && scl_d_ff;
    wire bus_start = scl_f && scl_d_ff && sda_d_ff && !sda_f; // R18
    wire bus_stop = scl_f && scl_d_ff && !sda_d_ff && sda_f; // R18

    // ================================================
    // Array, page buffer and protocol state
    reg [7:0] mem [0:(1<<`I2CEE_ADDR_W)-1];
    reg [7:0] pbuf [0:`I2CEE_PAGE_BYTES-1];
    reg [`I2CEE_PAGE_BYTES-1:0] pvld_ff;
    reg [2:0] st_ff;
    reg [3:0] bit_ff;
    reg ack_slot_ff;
    reg [7:0] rxsh_ff;
    reg [7:0] txsh_ff;
    reg [7:0] addr_hi_ff;
    reg [15:0] addr_ff;
    reg first_data_ff;
    reg wp_lat_ff;
    reg wr_pend_ff;
    reg read_end_nack_ff;
    reg sda_oe_n_ff;
    reg sda_out_ff;
    reg busy_ff;
    reg [8:0] page_ff;
    reg [7:0] prog_idx_ff;
    reg [19:0] wr_cnt_ff;
    reg push_ff;
    reg [14:0] push_data_ff;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [14:0] fifo_out_data;
    wire [7:0] rd_byte = mem[addr_ff];
    wire sel_match = (rxsh_ff[`I2CEE_TYPE_MSB:`I2CEE_TYPE_LSB] == `I2CEE_TYPE_CODE)
        && (rxsh_ff[`I2CEE_PINS_MSB:`I2CEE_PINS_LSB] == pins_f); // R17

    // Erased array at start of simulation
    integer k;
    initial
    begin
        for (k = 0; k < (1 << `I2CEE_ADDR_W); k = k + 1)
            mem[k] = `I2CEE_ERASED; // R12
    end

    // Entries carry page offset and data; drain stalls while programming
    i2cee_fifo #(.W(15), .D(FIFO_D), .AW(3)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(push_ff),
        .in_ready(fifo_in_ready),
        .in_data(push_data_ff),
        .out_valid(fifo_out_valid),
        .out_ready(!busy_ff),
        .out_data(fifo_out_data)
    );

    // ================================================
    // Serial protocol engine
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            st_ff <= ST_IDLE;
            bit_ff <= 4'h0;
            ack_slot_ff <= 1'b0;
            rxsh_ff <= 8'h00;
            txsh_ff <= 8'hff;
            addr_hi_ff <= 8'h00;
            addr_ff <= 16'h0000;
            first_data_ff <= 1'b0;
            wp_lat_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            read_end_nack_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
            sda_out_ff <= 1'b0;
            page_ff <= 9'h000;
            push_ff <= 1'b0;
            push_data_ff <= 15'h0000;
        end
        else if (clk_en)
        begin
            scl_d_ff <= scl_f;
            sda_d_ff <= sda_f;
            if (push_ff && fifo_in_ready)
                push_ff <= 1'b0;
            if (bus_start)
            begin
                // Pending data dropped; loaded address is kept
                st_ff <= ST_DSEL; // R21
                bit_ff <= 4'h0;
                ack_slot_ff <= 1'b0;
                wr_pend_ff <= 1'b0;
                sda_oe_n_ff <= 1'b1;
            end
            else if (bus_stop)
            begin
                st_ff <= ST_IDLE;
                ack_slot_ff <= 1'b0;
                wr_pend_ff <= 1'b0;
                sda_oe_n_ff <= 1'b1;
            end
            else if (st_ff != ST_IDLE && scl_rise)
            begin
                if (!ack_slot_ff)
                begin
                    rxsh_ff <= {rxsh_ff[6:0], sda_f}; // R19
                    bit_ff <= bit_ff + 4'h1;
                end
                else if (st_ff == ST_RD)
                    read_end_nack_ff <= sda_f; // R3
            end
            else if (st_ff != ST_IDLE && scl_fall)
            begin
                if (!ack_slot_ff && bit_ff == `I2CEE_BYTE_BITS)
                begin
                    ack_slot_ff <= 1'b1;
                    sda_oe_n_ff <= 1'b1;
                    case (st_ff)
                        ST_DSEL:
                        begin
                            if (sel_match && !busy_ff) // R6
                            begin
                                sda_oe_n_ff <= 1'b0; // R1
                                st_ff <= rxsh_ff[`I2CEE_DIR_BIT] ? ST_RD : ST_AH; // R14
                                read_end_nack_ff <= 1'b0;
                            end
                            else
                                st_ff <= ST_IDLE; // R20
                        end
                        ST_AH:
                        begin
                            sda_oe_n_ff <= 1'b0; // R2
                            addr_hi_ff <= rxsh_ff;
                            st_ff <= ST_AL;
                        end
                        ST_AL:
                        begin
                            sda_oe_n_ff <= 1'b0; // R2
                            addr_ff <= {addr_hi_ff, rxsh_ff}; // R15
                            page_ff <= addr_hi_ff[7:0] * 9'h002 + {8'h00, rxsh_ff[7]}; // R7
                            first_data_ff <= 1'b1;
                            st_ff <= ST_WD;
                        end
                        ST_WD:
                        begin
                            if (first_data_ff && wp_lat_ff)
                                st_ff <= ST_IDLE; // R11
                            else
                            begin
                                sda_oe_n_ff <= 1'b0; // R2
                                first_data_ff <= 1'b0;
                                wr_pend_ff <= 1'b1; // R5
                                push_ff <= 1'b1;
                                push_data_ff <= {addr_ff[6:0], rxsh_ff};
                                addr_ff <= {addr_ff[15:7], addr_ff[6:0] + 7'h01}; // R8
                            end
                        end
                        default:
                            sda_oe_n_ff <= 1'b1; // R3
                    endcase
                end
                else if (ack_slot_ff)
                begin
                    ack_slot_ff <= 1'b0;
                    bit_ff <= 4'h0;
                    sda_oe_n_ff <= 1'b1;
                    if (st_ff == ST_WD && first_data_ff)
                        wp_lat_ff <= wp_f; // R10
                    if (st_ff == ST_RD)
                    begin
                        if (read_end_nack_ff)
                            st_ff <= ST_IDLE; // R4
                        else
                        begin
                            txsh_ff <= rd_byte;
                            sda_oe_n_ff <= rd_byte[7]; // R16
                            addr_ff <= addr_ff + 16'h0001; // R13
                        end
                    end
                end
                else if (st_ff == ST_RD)
                begin
                    txsh_ff <= {txsh_ff[6:0], 1'b1};
                    sda_oe_n_ff <= txsh_ff[6]; // R19
                end
            end
        end
    end

    // ================================================
    // Page buffer fill and programming cycle
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            busy_ff <= 1'b0;
            pvld_ff <= {`I2CEE_PAGE_BYTES{1'b0}};
            prog_idx_ff <= 8'h00;
            wr_cnt_ff <= 20'h00000;
        end
        else if (clk_en)
        begin
            if (!busy_ff && bus_stop && wr_pend_ff)
            begin
                busy_ff <= 1'b1; // R9
                prog_idx_ff <= 8'h00;
                wr_cnt_ff <= 20'h00000;
            end
            else if (!busy_ff && bus_start)
                // A START while not busy drops bytes of an abandoned write
                pvld_ff <= {`I2CEE_PAGE_BYTES{1'b0}};
            if (fifo_out_valid && !busy_ff)
                pvld_ff[fifo_out_data[14:8]] <= 1'b1; // R8
            if (busy_ff)
            begin
                // Copy loaded bytes while counting out the cycle time
                if (prog_idx_ff < `I2CEE_PAGE_BYTES)
                begin
                    pvld_ff[prog_idx_ff[6:0]] <= 1'b0;
                    prog_idx_ff <= prog_idx_ff + 8'h01;
                end
                if (wr_cnt_ff >= WR_CYCLES[19:0] - 20'h00001)
                    busy_ff <= 1'b0;
                else
                    wr_cnt_ff <= wr_cnt_ff + 20'h00001;
            end
        end
    end

    // Page buffer and array storage
    always @(posedge core_clk)
    begin
        if (clk_en && fifo_out_valid && !busy_ff)
            pbuf[fifo_out_data[14:8]] <= fifo_out_data[7:0];
        if (clk_en && busy_ff && prog_idx_ff < `I2CEE_PAGE_BYTES && pvld_ff[prog_idx_ff[6:0]])
            mem[{page_ff, prog_idx_ff[6:0]}] <= pbuf[prog_idx_ff[6:0]];
    end

    assign sda_out = sda_out_ff;
    assign sda_oe_n = sda_oe_n_ff;
    assign write_busy = busy_ff;
endmodule

// ===== verification/i2cee_monitor.sv
// Purpose: pin-level checker for the two-wire memory slave
// Assumes: one clock domain, SCL far slower than core_clk
// Notes: bound into the slave top after the module
`timescale 1ns/100ps
module i2cee_monitor
#(
    parameter WR_CYCLES = 200
)
(
    // Clock and control
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    // Serial bus
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_n,
    // Straps and status
    input wire device_select_bit0,
    input wire device_select_bit1,
    input wire device_select_bit2,
    input wire write_protect,
    input wire write_busy
);
    int busy_cnt = 0;
    int low_cnt = 0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Counters for busy length and drive length
    always @(posedge core_clk)
    begin
        busy_cnt <= write_busy ? busy_cnt + (clk_en ? 1 : 0) : 0;
        low_cnt <= sda_oe_n ? 0 : low_cnt + 1;
    end
    // ==========================================
    // Pin relations
    a_open_drain_zero: assert property (sda_out == 1'b0)
        else $error("data value not zero");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> (sda_oe_n && !write_busy))
        else $error("outputs active after reset");
    a_busy_silent: assert property (write_busy |-> sda_oe_n)
        else $error("data driven while busy");
    a_busy_length: assert property ($fell(write_busy) |-> busy_cnt >= WR_CYCLES && busy_cnt <= WR_CYCLES + 1)
        else $error("busy length wrong");
    a_busy_after_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
        else $error("busy began without stop");
    a_change_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("drive changed while clock high");
    a_drive_holds_high: assert property ($rose(scl_in) && !sda_oe_n |=> !sda_oe_n [*4])
        else $error("drive dropped during clock high");
    a_drive_bounded: assert property (low_cnt < 150)
        else $error("data held low too long");
    // Main scenarios reached
    c_busy: cover property ($rose(write_busy));
    c_busy_end: cover property ($fell(write_busy));
    c_ack_high: cover property ($rose(scl_in) && !sda_oe_n);
endmodule
bind i2cee_slave i2cee_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .device_select_bit0(device_select_bit0), .device_select_bit1(device_select_bit1),
    .device_select_bit2(device_select_bit2), .write_protect(write_protect), .write_busy(write_busy));

// ===== verification/i2cee_master.sv
// Purpose: two-wire bus master model
// Assumes: SCL period 125 ns, low 75 ns, high 50 ns
// Notes: open drain, a one releases the line to the pull-up
`timescale 1ns/100ps
module i2cee_master
(
    // Bus lines
    output logic scl,
    output logic sda_o,
    input wire sda_i
);
    // ==========================================
    // Idle bus, clock stands still
    initial
    begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    // Change after fall, sample mid-high
    task automatic bit_xfer(input logic b, output logic r);
        #25 sda_o = b;
        #50 scl = 1'b1;
        #25 r = sda_i;
        #25 scl = 1'b0;
    endtask
    // Late data rise lets the slave release first
    task automatic start();
        #60 sda_o = 1'b1;
        #40 scl = 1'b1;
        #50 sda_o = 1'b0;
        #50 scl = 1'b0;
    endtask
    // Bus free time follows
    task automatic stop();
        #60 sda_o = 1'b0;
        #40 scl = 1'b1;
        #50 sda_o = 1'b1;
        #300;
    endtask
    // Byte out, MSB first
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask
    // Byte in, then ack or final nack
    task automatic rbyte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(!ack, r);
    endtask
endmodule

// ===== verification/i2c_eeprom_slave_access_tb.sv
// Purpose: self-checking bench for the two-wire memory slave
// Assumes: master model drives the bus, bench drives straps
// Notes: shortened write cycle keeps the run brief
`timescale 1ns/100ps
`include "i2cee_consts.vh"
module i2c_eeprom_slave_access_tb;
    localparam int WR = 400;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic wp = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [31:0] seed = 32'h487f;
    logic [15:0] cur = 16'h0;
    int errors = 0;
    int total_checks = 0;
    logic [7:0] mem [int];
    wire scl, sda_m, sda_oe_n, sda_out, write_busy;
    wire sda = sda_m & (sda_oe_n | sda_out);
    // ==========================================
    // Clock, master model, design
    always #4 core_clk = ~core_clk;
    i2cee_master m (.scl(scl), .sda_o(sda_m), .sda_i(sda));
    i2cee_slave #(.WR_CYCLES(WR), .FIFO_D(8)) DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_bit0(pins[0]),
        .device_select_bit1(pins[1]), .device_select_bit2(pins[2]), .write_protect(wp), .write_busy(write_busy));
    // ==========================================
    // Expectation helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_at(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
        total_checks++;
        if (got !== want)
        begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Bus transfers
    task automatic sel(input logic [3:0] ty, input logic [2:0] p, input logic dir, input logic want);
        logic a;
        m.start();
        m.wbyte({ty, p, dir}, a);
        chk({7'h0, a}, {7'h0, want}, "select ack");
    endtask
    task automatic adr(input logic [15:0] a);
        logic k1, k2;
        m.wbyte(a[15:8], k1);
        m.wbyte(a[7:0], k2);
        chk({6'h0, k1, k2}, 8'h3, "address acks");
    endtask
    // Protected writes expect a nacked first byte
    task automatic wr(input logic [15:0] a, input int n, input logic prot);
        logic ack;
        logic [7:0] d;
        sel(`I2CEE_TYPE_CODE, pins, 1'b0, 1'b1);
        adr(a);
        for (int k = 0; k < n; k++)
        begin
            seed = xs(seed);
            d = seed[7:0];
            m.wbyte(d, ack);
            chk({7'h0, ack}, {7'h0, !prot}, "data ack");
            if (!prot)
                mem[{a[15:7], a[6:0] + 7'(k)}] = d;
        end
        m.stop();
        chk({7'h0, write_busy}, {7'h0, !prot}, "busy after stop");
    endtask
    // Enable low must freeze the programming cycle
    task automatic idle();
        clk_en <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk({7'h0, write_busy}, 8'h1, "busy frozen");
        clk_en <= 1'b1;
        for (int i = 0; i < 2 * WR && write_busy; i++) @(posedge core_clk);
        chk({7'h0, write_busy}, 8'h0, "busy ends");
    endtask
    // Optional dummy write, then sequential read
    task automatic rd(input logic [15:0] a, input int n, input logic dummy);
        logic [7:0] d;
        logic [15:0] p;
        p = a;
        if (dummy)
        begin
            sel(`I2CEE_TYPE_CODE, pins, 1'b0, 1'b1);
            adr(a);
        end
        sel(`I2CEE_TYPE_CODE, pins, 1'b1, 1'b1);
        for (int k = 0; k < n; k++)
        begin
            m.rbyte(d, k < n - 1);
            chk(d, exp_at(p), "read data");
            p = p + 16'h1;
        end
        m.stop();
        cur = p;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        logic [15:0] a;
        repeat (2) @(posedge core_clk);
        seed = xs(seed);
        rst <= 1'b0;
        pins <= seed[2:0];
        repeat (6) @(posedge core_clk);
        for (int t = 0; t < 3; t++)
        begin
            seed = xs(seed);
            a = seed[15:0];
            wr(a, 1, 1'b0);
            sel(`I2CEE_TYPE_CODE, pins, 1'b0, 1'b0);
            m.stop();
            idle();
            rd(a, 1, 1'b1);
            rd(cur, 1, 1'b0);
        end
        $display("test byte write done");
        seed = xs(seed);
        a = seed[15:0];
        wr(a, 130, 1'b0);
        idle();
        rd({a[15:7], 7'h0}, 129, 1'b1);
        $display("test page write done");
        sel(`I2CEE_TYPE_CODE, pins ^ 3'h1, 1'b1, 1'b0);
        m.stop();
        sel((`I2CEE_TYPE_CODE ^ 4'h1), pins, 1'b0, 1'b0);
        m.stop();
        $display("test mismatch done");
        @(posedge core_clk);
        wp <= 1'b1;
        wr(a, 1, 1'b1);
        @(posedge core_clk);
        wp <= 1'b0;
        rd(a, 1, 1'b1);
        $display("test protect done");
        seed = xs(seed);
        a = seed[15:0];
        sel(`I2CEE_TYPE_CODE, pins, 1'b0, 1'b1);
        adr(a);
        m.stop();
        chk({7'h0, write_busy}, 8'h0, "no busy");
        rd(a, 1, 1'b0);
        $display("test dummy write done");
        rd(16'hffff, 2, 1'b1);
        rd(cur, 1, 1'b0);
        $display("test wrap done");
        tally_and_finish();
    end
    // Watchdog, about twice the expected run
    initial
    begin
        #700000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
